// >>> hw/arb_pkg.sv
// Constants and types shared by the four-way bus arbiter.
package arb_pkg;

	// ------------------------------------------------------------
	// Cluster size and reset levels
	// ------------------------------------------------------------
	localparam int         NUM_PROCS   = 4;
	localparam logic [3:0] TOKENS_IDLE = 4'h0;
	localparam logic       PRIO_FIXED  = 1'b1;
	localparam logic       FLAG_RESET  = 1'b0;

	// ------------------------------------------------------------
	// Grant states, Gray coded along idle and the owners
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_P1   = 3'h1,
		ST_P2   = 3'h3,
		ST_P3   = 3'h2,
		ST_P4   = 3'h6
	} grant_state_t;

endpackage : arb_pkg

// >>> hw/next_owner_pick.sv
// Picks the next bus owner among pending requests for either priority scheme, chosen by fixed_sel; fixed order whenever owner is zero.
module next_owner_pick (
	// Pending requests, bit i is processor i+1, active high
	input  wire logic [3:0] pending,
	// Current owner as one-hot, all zero when idle
	input  wire logic [3:0] owner,
	// Scheme: high fixed, low rotating
	input  wire logic       fixed_sel,
	// Chosen processor one-hot, zero when none
	output logic      [3:0] pick
);

	logic [3:0] cand;
	logic [7:0] dbl;
	logic [1:0] base;

	always_comb begin
		cand = pending & ~owner;
		pick = 4'h0;
		base = 2'h0;
		dbl  = {cand, cand};
		for (int i = 0; i < 4; i++) begin
			if (owner[i]) begin
				base = 2'(i);
			end
		end
		if (fixed_sel || owner == 4'h0) begin
			for (int i = 3; i >= 0; i--) begin
				if (cand[i]) begin
					pick = 4'h0;
					pick[i] = 1'b1;
				end
			end
		end else begin
			for (int k = 4; k >= 1; k--) begin
				if (dbl[3'(base) + 3'(k)]) begin
					pick = 4'h0;
					pick[2'(base + 2'(k))] = 1'b1;
				end
			end
		end
	end

endmodule // next_owner_pick

// >>> hw/four_way_bus_arbiter.sv
// Four-way external bus arbiter with parked token and selectable priority.
//
// Functional notes
// - All tokens are held low during reset and afterwards until a grant.
// - A sole requester gets its token high; all others stay low.
// - The token stays parked with the master until another processor requests.
// - Simultaneous requests grant exactly one processor, fixed or rotating.
// - Fixed priority: lowest numbered pending requester wins, processor one highest.
// - Rotating priority: next pending requester after current master, wrapping.
// - A priority scheme select input chooses fixed or rotating.
// - High on the select means fixed, low means rotating.
// - Four request inputs, four token outputs, reset and clock.
// - A post-reset delay flag plus three state flip-flops hold grant state.
// - The flag registers inactive reset; grants move only when flag set.
// - Idle drives all tokens low; owner n drives only token n high.
module four_way_bus_arbiter (
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	// Scheme select, high fixed, low rotating
	input  wire logic       priority_scheme_select,
	// Request lines from processors, active low
	input  wire logic       request_in_p1_n,
	input  wire logic       request_in_p2_n,
	input  wire logic       request_in_p3_n,
	input  wire logic       request_in_p4_n,
	// Token lines to processors, high grants the bus
	output logic            token_out_p1,
	output logic            token_out_p2,
	output logic            token_out_p3,
	output logic            token_out_p4
);

	// ------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------
	logic [3:0] req_s1_r;
	logic [3:0] req_s2_r;
	logic [3:0] req_s3_r;
	logic [3:0] req_raw;
	logic [3:0] req_nxt;
	logic [3:0] req_r;
	logic [2:0] sel_sh_r;
	logic       sel_nxt;
	logic       sel_r;

	assign req_raw = ~{request_in_p4_n, request_in_p3_n,
	                   request_in_p2_n, request_in_p1_n};

	always_comb begin
		req_nxt = req_r;
		sel_nxt = sel_r;
		for (int i = 0; i < 4; i++) begin
			if (req_s2_r[i] == req_s3_r[i]) begin
				req_nxt[i] = req_s3_r[i];
			end
		end
		if (sel_sh_r[1] == sel_sh_r[2]) begin
			sel_nxt = sel_sh_r[2];
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			req_s1_r <= 4'h0;
			req_s2_r <= 4'h0;
			req_s3_r <= 4'h0;
			req_r    <= 4'h0;
			sel_sh_r <= 3'h7;
			sel_r    <= arb_pkg::PRIO_FIXED;
		end else begin
			req_s1_r <= req_raw;
			req_s2_r <= req_s1_r;
			req_s3_r <= req_s2_r;
			req_r    <= req_nxt;
			sel_sh_r <= {sel_sh_r[1:0], priority_scheme_select};
			sel_r    <= sel_nxt;
		end
	end

	// ------------------------------------------------------------
	// Grant state machine
	// ------------------------------------------------------------
	arb_pkg::grant_state_t state_r;
	arb_pkg::grant_state_t state_nxt;
	logic                  delay_flag_r;
	logic                  delay_flag_nxt;
	logic [3:0]            owner;
	logic [3:0]            pick;
	logic [3:0]            token_r;
	logic [3:0]            token_nxt;

	always_comb begin
		unique case (state_r)
			arb_pkg::ST_P1: owner = 4'h1;
			arb_pkg::ST_P2: owner = 4'h2;
			arb_pkg::ST_P3: owner = 4'h4;
			arb_pkg::ST_P4: owner = 4'h8;
			default:        owner = 4'h0;
		endcase
	end

	next_owner_pick u_pick (
		.pending   (req_r),
		.owner     (owner),
		.fixed_sel (sel_r),
		.pick      (pick)
	);

	always_comb begin
		delay_flag_nxt = 1'b1;
		state_nxt      = state_r;
		// Owner keeps the bus while requesting; else hand over.
		if (delay_flag_r && (owner & req_r) == 4'h0) begin
			unique case (pick)
				4'h1:    state_nxt = arb_pkg::ST_P1;
				4'h2:    state_nxt = arb_pkg::ST_P2;
				4'h4:    state_nxt = arb_pkg::ST_P3;
				4'h8:    state_nxt = arb_pkg::ST_P4;
				default: state_nxt = state_r;
			endcase
		end
		unique case (state_nxt)
			arb_pkg::ST_P1: token_nxt = 4'h1;
			arb_pkg::ST_P2: token_nxt = 4'h2;
			arb_pkg::ST_P3: token_nxt = 4'h4;
			arb_pkg::ST_P4: token_nxt = 4'h8;
			default:        token_nxt = arb_pkg::TOKENS_IDLE;
		endcase
		if (state_r != arb_pkg::ST_IDLE && state_r != arb_pkg::ST_P1 &&
		    state_r != arb_pkg::ST_P2 && state_r != arb_pkg::ST_P3 &&
		    state_r != arb_pkg::ST_P4) begin
			state_nxt = arb_pkg::ST_IDLE;
			token_nxt = arb_pkg::TOKENS_IDLE;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r      <= arb_pkg::ST_IDLE;
			delay_flag_r <= arb_pkg::FLAG_RESET;
			token_r      <= arb_pkg::TOKENS_IDLE;
		end else begin
			state_r      <= state_nxt;
			delay_flag_r <= delay_flag_nxt;
			token_r      <= token_nxt;
		end
	end

	assign token_out_p1 = token_r[0];
	assign token_out_p2 = token_r[1];
	assign token_out_p3 = token_r[2];
	assign token_out_p4 = token_r[3];

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	sequence owner_drops_s;
		token_r[0] && req_r[0] ##1 token_r[0] && req_r == 4'h0;
	endsequence

	onehot_token_a: assert property ($onehot0(token_r))
		else $error("More than one token high.");
	idle_tokens_a: assert property (state_r == arb_pkg::ST_IDLE |->
		token_r == 4'h0)
		else $error("Token high while idle.");
	flag_first_a: assert property (!delay_flag_r |=>
		$stable(token_r))
		else $error("Grant moved before delay flag set.");
	park_keep_a: assert property ((token_r != 4'h0 &&
		(req_r & ~token_r) == 4'h0) |=> $stable(token_r))
		else $error("Parked token moved without a request.");
	hold_owner_a: assert property ((token_r & req_r) != 4'h0 |=>
		$stable(token_r))
		else $error("Token taken from a requesting owner.");
	sole_grant_a: assert property ((delay_flag_r && token_r == 4'h0 &&
		$onehot(req_r)) |=> token_r == $past(req_r))
		else $error("Sole requester not granted.");
	fixed_p1_a: assert property ((delay_flag_r && sel_r && req_r[0] &&
		(token_r & req_r) == 4'h0) |=> token_r == 4'h1)
		else $error("Fixed priority did not grant processor one.");
	rotate_a: assert property ((delay_flag_r && !sel_r && token_r == 4'h1
		&& req_r == 4'h6) |=> token_r == 4'h2)
		else $error("Rotating priority skipped next processor.");
	flag_set_a: assert property (1'b1 |=> delay_flag_r)
		else $error("Delay flag not set after reset.");
	drop_park_a: assert property (owner_drops_s |=>
		token_r == 4'h1)
		else $error("Owner lost token with no other request.");

endmodule // four_way_bus_arbiter

// >>> test/proc_cluster_model.sv
// Behavioural model of the four processors on the request lines.
module proc_cluster_model (
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	// Bus wanted by processor i+1, from the bench
	input  wire logic [3:0] want,
	// Request lines, active low
	output logic      [3:0] req_n
);
	timeunit 1ns;
	timeprecision 1ps;

	// All processors act as identity two, so none masters at reset.
	// With no master at reset no processor drives the strobes.
	// Each processor holds its request line high for three clocks after reset, then drives ~want.
	// Tenure is left unlimited; the bench releases each access.
	logic [1:0] hold_r;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			hold_r <= 2'h0;
			req_n  <= 4'hf;
		end else if (hold_r != 2'h3) begin
			hold_r <= hold_r + 2'h1;
			req_n  <= 4'hf;
		end else begin
			req_n  <= ~want;
		end
	end
endmodule // proc_cluster_model

// >>> test/four_way_bus_arbiter_bench.sv
// Self-checking bench for the four-way bus arbiter.
`define CHECK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin \
	num_errors++; $display("mismatch %s expected %h seen %h", nm, exp, got); \
	end end

module four_way_bus_arbiter_bench;
	timeunit 1ns;
	timeprecision 1ps;

	logic       ref_clk;
	logic       rst_n;
	logic       prio_sel;
	logic [3:0] want;
	logic [3:0] req_n;
	logic [3:0] tok;
	int         num_errors;
	int         tests_run;

	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	proc_cluster_model peer_u (.ref_clk(ref_clk), .rst_n(rst_n),
		.want(want), .req_n(req_n));

	four_way_bus_arbiter dut_u (.ref_clk(ref_clk), .rst_n(rst_n),
		.priority_scheme_select(prio_sel),
		.request_in_p1_n(req_n[0]), .request_in_p2_n(req_n[1]),
		.request_in_p3_n(req_n[2]), .request_in_p4_n(req_n[3]),
		.token_out_p1(tok[0]), .token_out_p2(tok[1]),
		.token_out_p3(tok[2]), .token_out_p4(tok[3]));

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic stop_test();
		$display("checks %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic req(input logic [3:0] w);
		@(posedge ref_clk);
		want <= w;
	endtask

	task automatic wait_tok(input logic [3:0] exp);
		int n;
		n = 0;
		while (tok !== exp && n < 20) begin
			@(posedge ref_clk);
			n++;
		end
		`CHECK("tokens", exp, tok)
		if (tok !== exp)
			stop_test();
	endtask

	task automatic hold_tok(input logic [3:0] exp);
		repeat (12) @(posedge ref_clk);
		`CHECK("held tokens", exp, tok)
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic test_idle();
		hold_tok(4'h0);
		$display("test idle done");
	endtask

	task automatic test_sole();
		req(4'h2);
		wait_tok(4'h2);
		req(4'h0);
		hold_tok(4'h2);
		$display("test sole done");
	endtask

	task automatic test_fixed();
		prio_sel <= 1'b1;
		req(4'h1);
		wait_tok(4'h1);
		req(4'hd);
		hold_tok(4'h1);
		req(4'hc);
		wait_tok(4'h4);
		req(4'ha);
		wait_tok(4'h2);
		req(4'h8);
		wait_tok(4'h8);
		$display("test fixed done");
	endtask

	task automatic test_rotating();
		prio_sel <= 1'b0;
		req(4'h1);
		wait_tok(4'h1);
		req(4'hd);
		hold_tok(4'h1);
		req(4'hc);
		wait_tok(4'h4);
		req(4'ha);
		wait_tok(4'h8);
		req(4'h2);
		wait_tok(4'h2);
		$display("test rotating done");
	endtask

	initial begin
		rst_n = 1'b0;
		prio_sel = 1'b1;
		want = 4'h0;
		num_errors = 0;
		tests_run = 0;
		repeat (20) @(posedge ref_clk);
		`CHECK("reset tokens", 4'h0, tok)
		rst_n <= 1'b1;
		test_idle();
		test_sole();
		test_fixed();
		test_rotating();
		stop_test();
	end
endmodule // four_way_bus_arbiter_bench
